// *** verilog/cce_cfg.svh ***
// constants of the compare command engine: ascii codes, limits, defaults, register map
`ifndef CCE_CFG_SVH
`define CCE_CFG_SVH
`define CCE_CH_DOLLAR 8'h24
`define CCE_CH_M 8'h4D
`define CCE_CH_C 8'h43
`define CCE_CH_X 8'h58
`define CCE_CH_SP 8'h20
`define CCE_CH_COMMA 8'h2C
`define CCE_CH_0 8'h30
`define CCE_CH_9 8'h39
`define CCE_CH_A 8'h41
`define CCE_CH_D 8'h44
`define CCE_CH_E 8'h45
`define CCE_CH_N 8'h4E
`define CCE_FLD_B 8'h42
`define CCE_FLD_L 8'h4C
`define CCE_FLD_R 8'h52
`define CCE_FLD_S 8'h53
`define CCE_FLD_P 8'h50
`define CCE_FLD_K 8'h4B
`define CCE_FLD_F 8'h46
`define CCE_FLD_NONE 8'h00
`define CCE_LIM16 11'h7CF
`define CCE_LIM32 11'h3E7
`define CCE_SKEW_MAX 14'h0009
`define CCE_FUNC_MAX 14'h0003
`define CCE_NUM_SAT 14'h03E8
`define CCE_DEF_CNT 11'h000
`define CCE_DEF_ADDR 11'h000
`define CCE_DEF_PODS 4'h3
`define CCE_DEF_SKEW 4'h4
`define CCE_DEF_FUNC 2'h0
`define CCE_DUMP_LAST 7'h44
`define CCE_SEC2_SLOT 7'h23
`define CCE_SEC1_SLOT 7'h05
`define CCE_END_SLOT 7'h41
`define CCE_REG_CTRL 8'h00
`define CCE_REG_STATUS 8'h04
`define CCE_REG_RESULT 8'h08
`define CCE_REG_ISTAT 8'h0C
`define CCE_REG_IMASK 8'h10
`define CCE_CTRL_START 0
`define CCE_CTRL_MODE32 1
`endif

// *** verilog/cce_pkg.sv ***
// types of the compare command engine
package cce_pkg;
   typedef enum logic [2:0] {PS_IDLE, PS_M, PS_MENU, PS_SETUP, PS_DUMP, PS_SKIP} cce_pstate_t;
   typedef enum logic [2:0] {C_IDLE, C_SEC, C_ISSUE, C_WAIT, C_EVAL, C_DONE} cce_cstate_t;
endpackage

// *** verilog/cce_top.sv ***
// compare command engine: text command parser, setup store, dump, compare run, apb registers
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "cce_cfg.svh"
module cce_top (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_VALID,
   output logic [7:0] TX_DATA,
   output logic TX_VALID,
   input wire logic TX_READY,
   output logic [10:0] SRC_ADDR,
   input wire logic [31:0] SRC_DATA,
   output logic [10:0] REF_ADDR,
   input wire logic [31:0] REF_DATA,
   output logic IRQ
);
   cce_pkg::cce_pstate_t pst;
   cce_pkg::cce_cstate_t cst;
   logic [7:0] fld;
   logic [13:0] num;
   logic [3:0] pods;
   logic bad;
   logic dsel;
   logic sec_ok;
   logic sel;
   logic commit_q;
   logic cmd_err;
   logic dump_go;
   logic mode32;
   logic [10:0] lim;
   logic [10:0] p_cnt [2];
   logic [10:0] p_src [2];
   logic [10:0] p_ref [2];
   logic [3:0] p_pod [2];
   logic [3:0] p_skw [2];
   logic [1:0] p_func;
   logic [10:0] s_cnt [2];
   logic [10:0] s_src [2];
   logic [10:0] s_ref [2];
   logic [3:0] s_pod [2];
   logic [3:0] s_skw [2];
   logic [1:0] s_func;
   logic rx_sp;
   logic rx_comma;
   logic term;
   logic start_setup;
   logic dumping;
   logic [6:0] dslot;
   logic dv;
   logic [7:0] dch;
   logic ds;
   logic [4:0] off;
   logic csec;
   logic [10:0] loc;
   logic signed [4:0] d;
   logic hit;
   logic [11:0] hits;
   logic halted;
   logic hsec;
   logic [10:0] hloc;
   logic done_ev;
   logic halt_ev;
   logic [31:0] pmask;
   logic eq;
   logic last;
   logic cond;
   logic acc;
   logic start_req;
   logic [3:0] istat;
   logic [3:0] imask;
   logic [3:0] ev;

   // decimal digit of a stored value for the printout
   function automatic logic [7:0] dec_char(input logic [10:0] v, input logic [1:0] pos);
      logic [10:0] q;
      q = v;
      case (pos)
         2'h3: q = v / 11'd1000;
         2'h2: q = v / 11'd100;
         2'h1: q = v / 11'd10;
         default: q = v;
      endcase
      dec_char = `CCE_CH_0 + {4'h0, 4'(q % 11'd10)};
   endfunction

   assign rx_sp = RX_DATA == `CCE_CH_SP;
   assign rx_comma = RX_DATA == `CCE_CH_COMMA;
   assign term = RX_VALID && pst == cce_pkg::PS_SETUP && (rx_sp || rx_comma);
   assign start_setup = RX_VALID && pst == cce_pkg::PS_MENU && RX_DATA == `CCE_CH_C;
   assign lim = mode32 ? `CCE_LIM32 : `CCE_LIM16;

   // character level parser: prefix, menu letter, field letter and its digits
   always_ff @(posedge CLK) begin
      dump_go <= 1'b0;
      if (!RST_B) begin
         pst <= cce_pkg::PS_IDLE;
         fld <= `CCE_FLD_NONE;
         num <= 14'h0000;
         pods <= 4'h0;
         bad <= 1'b0;
         dsel <= 1'b0;
      end else if (RX_VALID) begin
         unique case (pst)
            cce_pkg::PS_IDLE: if (RX_DATA == `CCE_CH_DOLLAR) pst <= cce_pkg::PS_M;
            cce_pkg::PS_M: pst <= (RX_DATA == `CCE_CH_M) ? cce_pkg::PS_MENU : cce_pkg::PS_IDLE;
            cce_pkg::PS_MENU: begin
               fld <= `CCE_FLD_NONE;
               dsel <= 1'b0;
               if (RX_DATA == `CCE_CH_C) pst <= cce_pkg::PS_SETUP;
               else if (RX_DATA == `CCE_CH_X) pst <= cce_pkg::PS_DUMP;
               else if (rx_comma) pst <= cce_pkg::PS_IDLE;
               else pst <= cce_pkg::PS_SKIP; // other menus are not ours
            end
            cce_pkg::PS_SETUP: begin
               if (rx_sp || rx_comma) begin
                  fld <= `CCE_FLD_NONE;
                  if (rx_comma) pst <= cce_pkg::PS_IDLE;
               end else if (fld == `CCE_FLD_NONE) begin
                  fld <= RX_DATA;
                  num <= 14'h0000;
                  pods <= 4'h0;
                  bad <= 1'b0;
               end else if (RX_DATA >= `CCE_CH_0 && RX_DATA <= `CCE_CH_9 && fld != `CCE_FLD_P) begin
                  // stop accumulating once the value reaches 1000 and flag the field bad, so a long digit run cannot wrap into range
                  if (num < `CCE_NUM_SAT) num <= 14'(num * 14'd10 + {6'h00, RX_DATA - `CCE_CH_0});
                  else bad <= 1'b1;
               end else if (fld == `CCE_FLD_P && RX_DATA >= `CCE_CH_A && RX_DATA <= `CCE_CH_D) begin
                  pods[2'(RX_DATA - `CCE_CH_A)] <= 1'b1;
               end else begin
                  bad <= 1'b1;
               end
            end
            cce_pkg::PS_DUMP: begin
               if (rx_comma) begin
                  pst <= cce_pkg::PS_IDLE;
                  dump_go <= dsel;
               end else if (!rx_sp) begin
                  dsel <= RX_DATA == `CCE_CH_C;
               end
            end
            cce_pkg::PS_SKIP: if (rx_comma) pst <= cce_pkg::PS_IDLE;
         endcase
      end
   end

   // pending copy of the setup, edited field by field and kept apart until the comma
   always_ff @(posedge CLK) begin
      cmd_err <= 1'b0;
      commit_q <= 1'b0;
      if (!RST_B) begin
         sec_ok <= 1'b0;
         sel <= 1'b0;
         p_func <= `CCE_DEF_FUNC;
         for (int i = 0; i < 2; i++) begin
            p_cnt[i] <= `CCE_DEF_CNT;
            p_src[i] <= `CCE_DEF_ADDR;
            p_ref[i] <= `CCE_DEF_ADDR;
            p_pod[i] <= `CCE_DEF_PODS;
            p_skw[i] <= `CCE_DEF_SKEW;
         end
      end else if (start_setup) begin
         sec_ok <= 1'b0;
         sel <= 1'b0;
         p_func <= s_func;
         for (int i = 0; i < 2; i++) begin
            p_cnt[i] <= s_cnt[i];
            p_src[i] <= s_src[i];
            p_ref[i] <= s_ref[i];
            p_pod[i] <= s_pod[i];
            p_skw[i] <= s_skw[i];
         end
      end else if (term) begin
         commit_q <= rx_comma;
         if (fld != `CCE_FLD_NONE) begin
            if (bad) cmd_err <= 1'b1;
            else if (fld == `CCE_FLD_B) begin
               if (num == 14'h0001 || num == 14'h0002) begin
                  sel <= num[1];
                  sec_ok <= 1'b1;
               end else cmd_err <= 1'b1;
            end else if (fld == `CCE_FLD_F) begin
               if (num <= `CCE_FUNC_MAX) p_func <= num[1:0];
               else cmd_err <= 1'b1;
            end else if (!sec_ok) cmd_err <= 1'b1;
            else if (fld == `CCE_FLD_L && num <= {3'h0, lim}) p_cnt[sel] <= num[10:0];
            else if (fld == `CCE_FLD_S && num <= {3'h0, lim}) p_src[sel] <= num[10:0];
            else if (fld == `CCE_FLD_R && num <= {3'h0, lim}) p_ref[sel] <= num[10:0];
            else if (fld == `CCE_FLD_P) p_pod[sel] <= pods;
            else if (fld == `CCE_FLD_K && num <= `CCE_SKEW_MAX) p_skw[sel] <= num[3:0];
            else cmd_err <= 1'b1;
         end
      end
   end

   // stored setup per section, taken over one cycle after the comma
   always_ff @(posedge CLK) begin
      if (!RST_B) s_func <= `CCE_DEF_FUNC;
      else if (commit_q) s_func <= p_func;
   end
   for (genvar g = 0; g < 2; g++) begin : g_sec
      always_ff @(posedge CLK) begin
         if (!RST_B) begin
            s_cnt[g] <= `CCE_DEF_CNT;
            s_src[g] <= `CCE_DEF_ADDR;
            s_ref[g] <= `CCE_DEF_ADDR;
            s_pod[g] <= `CCE_DEF_PODS;
            s_skw[g] <= `CCE_DEF_SKEW;
         end else if (commit_q) begin
            s_cnt[g] <= p_cnt[g];
            s_src[g] <= p_src[g];
            s_ref[g] <= p_ref[g];
            s_pod[g] <= p_pod[g];
            s_skw[g] <= p_skw[g];
         end
      end
   end

   // printout slot decode: fixed slots, absent pods are skipped slots
   always_comb begin
      dv = 1'b1;
      dch = `CCE_CH_SP;
      ds = dslot >= `CCE_SEC2_SLOT;
      off = ds ? 5'(dslot - `CCE_SEC2_SLOT) : 5'(dslot - `CCE_SEC1_SLOT);
      if (dslot < `CCE_SEC1_SLOT) begin
         case (dslot[2:0])
            3'h0: dch = `CCE_CH_M;
            3'h1: dch = `CCE_CH_C;
            3'h3: dch = `CCE_FLD_F;
            3'h4: dch = `CCE_CH_0 + {6'h00, s_func};
            default: dch = `CCE_CH_SP;
         endcase
      end else if (dslot >= `CCE_END_SLOT) begin
         case (dslot - `CCE_END_SLOT)
            7'h1: dch = `CCE_CH_E;
            7'h2: dch = `CCE_CH_N;
            7'h3: dch = `CCE_CH_D;
            default: dch = `CCE_CH_SP;
         endcase
      end else begin
         case (off)
            5'd1: dch = `CCE_FLD_B;
            5'd2: dch = `CCE_CH_0 + {7'h00, 1'b1} + {7'h00, ds};
            5'd4: dch = `CCE_FLD_L;
            5'd5, 5'd6, 5'd7, 5'd8: dch = dec_char(s_cnt[ds], 2'(5'd8 - off));
            5'd10: dch = `CCE_FLD_R;
            5'd11, 5'd12, 5'd13, 5'd14: dch = dec_char(s_ref[ds], 2'(5'd14 - off));
            5'd16: dch = `CCE_FLD_S;
            5'd17, 5'd18, 5'd19, 5'd20: dch = dec_char(s_src[ds], 2'(5'd20 - off));
            5'd22: dch = `CCE_FLD_P;
            5'd23, 5'd24, 5'd25, 5'd26: begin
               dv = s_pod[ds][2'(off - 5'd23)];
               dch = `CCE_CH_A + {6'h00, 2'(off - 5'd23)};
            end
            5'd28: dch = `CCE_FLD_K;
            5'd29: dch = `CCE_CH_0 + {4'h0, s_skw[ds]};
            default: dch = `CCE_CH_SP;
         endcase
      end
   end

   // printout sender, stalls on tx_ready so no character is dropped
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         dumping <= 1'b0;
         dslot <= 7'h00;
         TX_DATA <= 8'h00;
         TX_VALID <= 1'b0;
      end else begin
         if (TX_VALID && TX_READY) TX_VALID <= 1'b0;
         if (dump_go && !dumping) begin
            dumping <= 1'b1;
            dslot <= 7'h00;
         end else if (dumping && (!TX_VALID || TX_READY)) begin
            if (dv) begin
               TX_DATA <= dch;
               TX_VALID <= 1'b1;
            end
            dslot <= dslot + 7'h01;
            if (dslot == `CCE_DUMP_LAST) dumping <= 1'b0;
         end
      end
   end

   // compare datapath: pod a in the low byte up to pod d in the high byte
   assign pmask = {{8{s_pod[csec][3]}}, {8{s_pod[csec][2]}}, {8{s_pod[csec][1]}}, {8{s_pod[csec][0]}}};
   assign eq = ((SRC_DATA ^ REF_DATA) & pmask) == 32'h00000000;
   assign last = eq || (d == $signed({1'b0, s_skw[csec]}));
   assign cond = s_func[0] ? !(hit || eq) : (hit || eq);

   // compare sequencer: one probe per offset, memories answer one cycle after the address
   always_ff @(posedge CLK) begin
      done_ev <= 1'b0;
      halt_ev <= 1'b0;
      if (!RST_B) begin
         cst <= cce_pkg::C_IDLE;
         csec <= 1'b0;
         loc <= 11'h000;
         d <= 5'sh00;
         hit <= 1'b0;
         hits <= 12'h000;
         halted <= 1'b0;
         hsec <= 1'b0;
         hloc <= 11'h000;
         SRC_ADDR <= 11'h000;
         REF_ADDR <= 11'h000;
      end else begin
         unique case (cst)
            cce_pkg::C_IDLE: if (start_req) begin
               cst <= cce_pkg::C_SEC;
               csec <= 1'b0;
               hits <= 12'h000;
               halted <= 1'b0;
            end
            cce_pkg::C_SEC: begin
               if (s_cnt[csec] != 11'h000) begin
                  loc <= 11'h000;
                  d <= -$signed({1'b0, s_skw[csec]});
                  hit <= 1'b0;
                  cst <= cce_pkg::C_ISSUE;
               end else if (csec) cst <= cce_pkg::C_DONE;
               else csec <= 1'b1;
            end
            cce_pkg::C_ISSUE: begin
               // out of range offsets wrap; keeping the span inside memory is the host's care
               SRC_ADDR <= s_src[csec] + loc;
               REF_ADDR <= s_ref[csec] + loc + {{6{d[4]}}, d};
               cst <= cce_pkg::C_WAIT;
            end
            cce_pkg::C_WAIT: cst <= cce_pkg::C_EVAL;
            cce_pkg::C_EVAL: begin
               if (!last) begin
                  hit <= hit || eq;
                  d <= d + 5'sh01;
                  cst <= cce_pkg::C_ISSUE;
               end else if (cond && !s_func[1]) begin
                  halted <= 1'b1;
                  halt_ev <= 1'b1;
                  hsec <= csec;
                  hloc <= loc;
                  cst <= cce_pkg::C_DONE;
               end else begin
                  if (cond) hits <= hits + 12'h001;
                  hit <= 1'b0;
                  d <= -$signed({1'b0, s_skw[csec]});
                  if (loc + 11'h001 != s_cnt[csec]) begin
                     loc <= loc + 11'h001;
                     cst <= cce_pkg::C_ISSUE;
                  end else if (csec) cst <= cce_pkg::C_DONE;
                  else begin
                     csec <= 1'b1;
                     cst <= cce_pkg::C_SEC;
                  end
               end
            end
            cce_pkg::C_DONE: begin
               done_ev <= 1'b1;
               cst <= cce_pkg::C_IDLE;
            end
         endcase
      end
   end

   // apb slave: one wait state; writes take effect on the pready edge, read data is captured on the edge that raises pready
   assign acc = PSEL && PENABLE && PREADY;
   assign start_req = acc && PWRITE && PADDR == `CCE_REG_CTRL && PWDATA[`CCE_CTRL_START];
   assign ev = {commit_q, cmd_err, halt_ev, done_ev};
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL && PENABLE && !PREADY;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h00000000;
         if (PSEL && PENABLE && !PREADY) begin
            case (PADDR)
               `CCE_REG_CTRL: PRDATA <= {30'h00000000, mode32, 1'b0};
               `CCE_REG_STATUS: PRDATA <= {28'h0000000, dumping, sec_ok, halted, cst != cce_pkg::C_IDLE};
               `CCE_REG_RESULT: PRDATA <= halted ? {15'h0000, hsec, 5'h00, hloc} : {20'h00000, hits};
               `CCE_REG_ISTAT: PRDATA <= {28'h0000000, istat};
               `CCE_REG_IMASK: PRDATA <= {28'h0000000, imask};
               default: PSLVERR <= 1'b1;
            endcase
         end
      end
   end

   // mode, mask and sticky status; a new event beats a clear in the same cycle
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         mode32 <= 1'b0;
         imask <= 4'h0;
         istat <= 4'h0;
         IRQ <= 1'b0;
      end else begin
         if (acc && PWRITE && PADDR == `CCE_REG_CTRL) mode32 <= PWDATA[`CCE_CTRL_MODE32];
         if (acc && PWRITE && PADDR == `CCE_REG_IMASK) imask <= PWDATA[3:0];
         istat <= (istat & ~((acc && PWRITE && PADDR == `CCE_REG_ISTAT) ? PWDATA[3:0] : 4'h0)) | ev;
         IRQ <= |(istat & imask);
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   a_commit_comma: assert property (commit_q |-> $past(RX_VALID && rx_comma && pst == cce_pkg::PS_SETUP))
      else $error("setup committed without a comma");
   a_sec_select: assert property (term && !bad && fld == `CCE_FLD_B && num == 14'h0002 |=> sel && sec_ok)
      else $error("section two not selected");
   a_no_sec_hold: assert property (term && !sec_ok && fld == `CCE_FLD_L && !start_setup
      |=> p_cnt[0] == $past(p_cnt[0]) && p_cnt[1] == $past(p_cnt[1]) && cmd_err)
      else $error("count taken without a section");
   a_count_limit: assert property (term && sec_ok && fld == `CCE_FLD_L && num > {3'h0, lim}
      |=> p_cnt[$past(sel)] == $past(p_cnt[sel]))
      else $error("count beyond limit accepted");
   a_skew_range: assert property (p_skw[0] <= 4'h9 && p_skw[1] <= 4'h9 && s_skw[0] <= 4'h9 && s_skw[1] <= 4'h9)
      else $error("skew beyond nine");
   a_halt_func: assert property (halt_ev |-> !s_func[1] ##1 done_ev)
      else $error("halt outside a halt function");
   a_count_step: assert property (cst == cce_pkg::C_EVAL && last && cond && s_func[1] |=> hits == $past(hits) + 12'h001)
      else $error("count not advanced");
   a_match_skip: assert property (cst == cce_pkg::C_EVAL && eq && s_func == 2'h1 |=> !halt_ev && !halted)
      else $error("equal location treated as mismatch");
   a_dump_start: assert property (dump_go && !dumping |=> dumping ##1 TX_VALID && TX_DATA == `CCE_CH_M)
      else $error("printout did not start");
   a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
      else $error("tx character dropped");
endmodule

// *** tb/cce_host.sv ***
// model of the remote host terminal: sends command strings and takes printout chars
`timescale 1ns/1ps
module cce_host (
   input wire logic clk,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic tx_ready
);
   string got = "";
   logic stall = 1'b0;

   initial begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
   end

   // one char per edge, fields split by spaces, comma last; an idle line shows the inverse char
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         @(posedge clk);
         rx_data <= s[i];
         rx_valid <= 1'b1;
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
   endtask

   // stalling toggles ready, so a char sent straight after an accepted one must wait out a refused cycle
   always @(posedge clk) begin
      if (tx_valid && tx_ready)
         got = $sformatf("%s%c", got, tx_data);
      tx_ready <= stall ? ~tx_ready : 1'b1;
   end
endmodule

// *** tb/tb_cce_top.sv ***
// self-checking bench of the compare command engine
`timescale 1ns/1ps
module tb_cce_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] rx_data;
   logic rx_valid;
   logic [7:0] tx_data;
   logic tx_valid;
   logic tx_ready;
   logic [10:0] src_addr;
   logic [10:0] ref_addr;
   logic [31:0] src_data = 32'h0;
   logic [31:0] ref_data = 32'h0;
   logic irq;
   logic [31:0] src_mem [0:2047];
   logic [31:0] ref_mem [0:2047];
   int n_fail = 0;
   int n_checks = 0;

   always #2 clk = ~clk;

   cce_top dut_u (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .RX_DATA(rx_data), .RX_VALID(rx_valid), .TX_DATA(tx_data), .TX_VALID(tx_valid),
      .TX_READY(tx_ready), .SRC_ADDR(src_addr), .SRC_DATA(src_data), .REF_ADDR(ref_addr),
      .REF_DATA(ref_data), .IRQ(irq));

   cce_host host_u (.clk(clk), .tx_data(tx_data), .tx_valid(tx_valid), .rx_data(rx_data),
      .rx_valid(rx_valid), .tx_ready(tx_ready));

   // both memories answer one cycle after the address
   always @(posedge clk) begin
      src_data <= src_mem[src_addr];
      ref_data <= ref_mem[ref_addr];
   end

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_str(input string got, input string exp);
      n_checks++;
      if (got != exp) begin
         n_fail++;
         $display("[FAIL] %0t printout got '%s'", $time, got);
      end
   endtask

   // apb transfer: setup, access held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // exactly one wait state: pready is seen at the second access edge
      chk32(32'(k), 32'h2, "apb wait states");
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input string what);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk32(q & m, exp, what);
   endtask

   task automatic t_reset;
      logic [31:0] q;
      logic e;
      rd_chk(8'h04, 32'h0, 32'hFFFFFFFF, "status at reset");
      rd_chk(8'h08, 32'h0, 32'hFFFFFFFF, "result at reset");
      rd_chk(8'h0C, 32'h0, 32'hFFFFFFFF, "events at reset");
      rd_chk(8'h10, 32'h0, 32'hFFFFFFFF, "mask at reset");
      apb(1'b0, 8'h20, 32'h0, q, e);
      chk32({e, q[30:0]}, 32'h80000000, "unmapped read");
      $display("test reset done");
   endtask

   // printout request with a stalling sink; nothing may follow the end token
   task automatic t_dump(input string exp);
      int k;
      host_u.got = "";
      host_u.stall <= 1'b1;
      host_u.send("$MX C ,");
      k = 0;
      while (host_u.got.len() < exp.len() && k < 2000) begin
         @(posedge clk);
         k++;
      end
      repeat (8) @(posedge clk);
      chk_str(host_u.got, exp);
      $display("test dump done");
   endtask

   // commit lands two edges after the comma
   task automatic t_setup;
      host_u.send("$MC L0007 B1 L0003 PBD K2 B2 S0009 F1,");
      repeat (3) @(posedge clk);
      rd_chk(8'h0C, 32'h4, 32'h4, "field before section");
      wr(8'h0C, 32'hF);
      host_u.send("$MC K7 B1 R0004");
      repeat (3) @(posedge clk);
      rd_chk(8'h0C, 32'h0, 32'h8, "commit before comma");
      rd_chk(8'h04, 32'h4, 32'h4, "section chosen");
      host_u.send(",");
      repeat (3) @(posedge clk);
      rd_chk(8'h0C, 32'h8, 32'h8, "commit on comma");
      t_dump("MC F1 B1 L0003 R0004 S0000 PBD K2 B2 L0000 R0000 S0009 PAB K4 END");
      $display("test setup done");
   endtask

   task automatic t_limits;
      wr(8'h0C, 32'hF);
      host_u.send("$MC B1 L1999 S2000,");
      repeat (3) @(posedge clk);
      rd_chk(8'h0C, 32'h4, 32'h4, "source over 16 bit limit");
      wr(8'h00, 32'h2);
      rd_chk(8'h00, 32'h2, 32'hFFFFFFFF, "mode readback");
      wr(8'h0C, 32'hF);
      host_u.send("$MC B2 R1000 R0999 L1000 L0999,");
      repeat (3) @(posedge clk);
      rd_chk(8'h0C, 32'h4, 32'h4, "reference over 32 bit limit");
      t_dump("MC F1 B1 L1999 R0004 S0000 PBD K2 B2 L0999 R0999 S0009 PAB K4 END");
      $display("test limits done");
   endtask

   // five locations, skew one, pod A only; matches at 0, 1 and 4
   task automatic t_compare;
      logic [31:0] q;
      logic e;
      logic [31:0] res [4] = '{32'h0, 32'h2, 32'h3, 32'h2};
      logic [7:0] rb [6] = '{8'h01, 8'h00, 8'h02, 8'h09, 8'h07, 8'h05};
      for (int i = 0; i < 5; i++)
         src_mem[i] = {24'hABCDEF, 8'(i + 1)};
      for (int j = 0; j < 6; j++)
         ref_mem[100 + j] = {24'h123456, rb[j]};
      host_u.send("$MC F0 B1 L0005 R0100 S0000 PA K1 B2 L0000,");
      for (int f = 0; f < 4; f++) begin
         host_u.send($sformatf("$MC F%0d,", f));
         repeat (3) @(posedge clk);
         wr(8'h0C, 32'hF);
         wr(8'h10, (f == 3) ? 32'h0 : 32'h1);
         wr(8'h00, 32'h1);
         q = 32'h1;
         for (int k = 0; k < 100 && q[0] !== 1'b0; k++)
            apb(1'b0, 8'h04, 32'h0, q, e);
         chk32(q & 32'h3, (f < 2) ? 32'h2 : 32'h0, "halt state");
         rd_chk(8'h08, res[f], 32'h1FFFF, "result");
         rd_chk(8'h0C, (f < 2) ? 32'h3 : 32'h1, 32'h3, "events");
         chk32({31'h0, irq}, (f == 3) ? 32'h0 : 32'h1, "irq level");
         wr(8'h0C, 32'h3);
         repeat (3) @(posedge clk);
         chk32({31'h0, irq}, 32'h0, "irq cleared");
      end
      $display("test compare done");
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      for (int i = 0; i < 2048; i++) begin
         src_mem[i] = 32'h0;
         ref_mem[i] = 32'h0;
      end
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_dump("MC F0 B1 L0000 R0000 S0000 PAB K4 B2 L0000 R0000 S0000 PAB K4 END");
      t_setup();
      t_limits();
      t_compare();
      results();
   end

   // whole run needs about a thousand cycles
   initial begin
      #200000;
      n_fail++;
      $display("[FAIL] %0t watchdog expired", $time);
      results();
   end
endmodule
